// ---- acd_cmd_decoder.sv ----
// command decoder: accumulator copies, flag clear, interrupt enables, x math
// assumes a byte source and sink synchronous to clock, parameter store outside
`timescale 1ns/1ps
`include "acd_regs.svh"
module acd_cmd_decoder
    import acd_pkg::*;
#(
    parameter int         N_IRQ       = 32,
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter logic [7:0] HOST_ADDR   = 8'h02
) (
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    input  wire logic                    rx_valid,
    input  wire logic [7:0]              rx_data,
    output wire logic                    rx_ready,
    output wire logic                    tx_valid,
    output wire logic [7:0]              tx_data,
    input  wire logic                    tx_ready,
    input  wire logic                    accu_load,
    input  wire logic [31:0]             accu_load_val,
    input  wire logic [`ACD_N_FLAGS-1:0] flag_set,
    output wire logic [31:0]             accu,
    output wire logic [31:0]             x_reg,
    output wire logic [`ACD_N_FLAGS-1:0] err_flags,
    output wire logic [N_IRQ-1:0]        irq_enable,
    output wire logic                    irq_global,
    output wire acd_param_wr_t           param_wr,
    output wire logic                    frame_reject
);
    // -------------------------------------------------------------
    // storage
    // -------------------------------------------------------------
    acd_state_t               state_q;      // sequencer
    acd_state_t               state_d;      // next sequencer state
    logic [3:0]               cnt_q;        // byte index
    logic [7:0]               frame_q [9];  // received frame
    logic [7:0]               reply_q [9];  // reply frame
    logic                     rx_ready_q;   // accepting bytes
    logic                     tx_valid_q;   // reply byte present
    logic [7:0]               tx_data_q;    // reply byte
    logic [31:0]              accu_q;       // accumulator
    logic [31:0]              x_q;          // x register
    logic [`ACD_N_FLAGS-1:0]  err_q;        // error flags
    logic [`ACD_N_FLAGS-1:0]  clr_hit;      // per-flag clear
    logic [N_IRQ-1:0]         irq_en_q;     // per-irq enables
    logic                     irq_glob_q;   // global enable
    acd_param_wr_t            pwr_q;        // parameter write
    logic                     reject_q;     // bad frame pulse
    logic [7:0]               sum;          // frame byte sum
    logic [7:0]               rsum;         // reply byte sum
    logic [7:0]               ins;          // instruction byte
    logic [7:0]               typ;          // type byte
    logic                     supported;    // instruction handled here
    logic                     frame_ok;     // address and sum good
    logic                     exec_go;      // execute this cycle

    assign ins = frame_q[`ACD_B_INSTR];
    assign typ = frame_q[`ACD_B_TYPE];

    // -------------------------------------------------------------
    // frame checking
    // -------------------------------------------------------------
    // sum of the eight leading bytes, wraps at 256
    always_comb begin
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            sum = sum + frame_q[i];
        end
    end

    assign supported = (ins == `ACD_INS_ACCU_AXIS) || (ins == `ACD_INS_ACCU_GLOBAL) ||
                       (ins == `ACD_INS_CLEAR_ERR) || (ins == `ACD_INS_IRQ_EN) ||
                       (ins == `ACD_INS_IRQ_DIS) || (ins == `ACD_INS_ACCU_X);
    // frames for another address get no reply, only a frame_reject pulse, as on a shared line
    assign frame_ok = (sum == frame_q[`ACD_B_SUM]) && (frame_q[`ACD_B_ADDR] == MODULE_ADDR);
    assign exec_go  = (state_q == ACD_ST_EXEC) && frame_ok && supported;

    // -------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------
    // next state: nine bytes in, one check cycle, nine bytes out
    always_comb begin
        state_d = state_q;
        case (state_q)
            ACD_ST_RX: begin
                if (rx_valid && rx_ready_q && cnt_q == `ACD_FRAME_LEN - 4'h1) state_d = ACD_ST_EXEC;
            end
            ACD_ST_EXEC: begin
                state_d = exec_go ? ACD_ST_TX : ACD_ST_RX;
            end
            ACD_ST_TX: begin
                if (tx_valid_q && tx_ready && cnt_q == `ACD_FRAME_LEN) state_d = ACD_ST_RX;
            end
            default: state_d = ACD_ST_RX;
        endcase
    end

    // state register and registered ready
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= ACD_ST_RX;
            rx_ready_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            rx_ready_q <= (state_d == ACD_ST_RX);
        end
    end

    // byte index, shared by receive and transmit
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
        end else if (state_q == ACD_ST_RX && rx_valid && rx_ready_q) begin
            cnt_q <= (cnt_q == `ACD_FRAME_LEN - 4'h1) ? 4'h0 : cnt_q + 4'h1;
        end else if (state_q == ACD_ST_TX && (!tx_valid_q || tx_ready)) begin
            cnt_q <= (cnt_q == `ACD_FRAME_LEN) ? 4'h0 : cnt_q + 4'h1;
        end
    end

    // frame capture in wire order: addr, instr, type, bank, value msb first, sum
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 9; i++) frame_q[i] <= 8'h00;
        end else if (state_q == ACD_ST_RX && rx_valid && rx_ready_q) begin
            frame_q[cnt_q] <= rx_data;
        end
    end

    // -------------------------------------------------------------
    // reply
    // -------------------------------------------------------------
    // checksum over the reply header and current accumulator
    always_comb begin
        rsum = HOST_ADDR + MODULE_ADDR + `ACD_STATUS_OK + ins;
        rsum = rsum + accu_q[31:24] + accu_q[23:16] + accu_q[15:8] + accu_q[7:0];
    end

    // reply is built before execution; its value field is accumulator content
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 9; i++) reply_q[i] <= 8'h00;
        end else if (exec_go) begin
            reply_q[0] <= HOST_ADDR;
            reply_q[1] <= MODULE_ADDR;
            reply_q[2] <= `ACD_STATUS_OK;
            reply_q[3] <= ins;
            reply_q[4] <= accu_q[31:24];
            reply_q[5] <= accu_q[23:16];
            reply_q[6] <= accu_q[15:8];
            reply_q[7] <= accu_q[7:0];
            reply_q[8] <= rsum;
        end
    end

    // byte sender; one idle cycle before the first byte
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
        end else if (state_q == ACD_ST_TX && (!tx_valid_q || tx_ready)) begin
            if (cnt_q == `ACD_FRAME_LEN) begin
                tx_valid_q <= 1'b0;
            end else begin
                tx_valid_q <= 1'b1;
                tx_data_q  <= reply_q[cnt_q];
            end
        end
    end

    // -------------------------------------------------------------
    // accumulator and x register
    // -------------------------------------------------------------
    // x-math execution wins over an outside load in the same cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            accu_q <= 32'h0000_0000;
            x_q    <= 32'h0000_0000;
        end else if (exec_go && ins == `ACD_INS_ACCU_X) begin
            case (acd_xop_t'(typ))
                ACD_XOP_ADD:  accu_q <= accu_q + x_q;
                ACD_XOP_SUB:  accu_q <= accu_q - x_q;
                ACD_XOP_MUL:  accu_q <= $signed(accu_q) * $signed(x_q);
                // divide by zero leaves the accumulator as it was
                ACD_XOP_DIV:  if (x_q != 32'h0) accu_q <= $signed(accu_q) / $signed(x_q);
                ACD_XOP_MOD:  if (x_q != 32'h0) accu_q <= $signed(accu_q) % $signed(x_q);
                ACD_XOP_AND:  accu_q <= accu_q & x_q;
                ACD_XOP_OR:   accu_q <= accu_q | x_q;
                ACD_XOP_XOR:  accu_q <= accu_q ^ x_q;
                ACD_XOP_NOT:  x_q <= ~x_q;
                ACD_XOP_LOAD: x_q <= accu_q;
                ACD_XOP_SWAP: begin
                    accu_q <= x_q;
                    x_q    <= accu_q;
                end
                default: ;  // unknown operation: no change
            endcase
        end else if (accu_load) begin
            accu_q <= accu_load_val;
        end
    end

    // -------------------------------------------------------------
    // parameter write strobe
    // -------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pwr_q <= '0;
        end else begin
            pwr_q.valid  <= exec_go && (ins == `ACD_INS_ACCU_AXIS || ins == `ACD_INS_ACCU_GLOBAL);
            pwr_q.global <= (ins == `ACD_INS_ACCU_GLOBAL);
            pwr_q.index  <= typ;
            pwr_q.bank   <= frame_q[`ACD_B_BANK];
            pwr_q.value  <= accu_q;
        end
    end

    // rejected frame pulse
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) reject_q <= 1'b0;
        else        reject_q <= (state_q == ACD_ST_EXEC) && !exec_go;
    end

    // -------------------------------------------------------------
    // error flags and interrupt enables
    // -------------------------------------------------------------
    // per flag: a set arriving with its clear wins, so no event is lost
    for (genvar f = 0; f < `ACD_N_FLAGS; f++) begin : g_flag
        assign clr_hit[f] = exec_go && ins == `ACD_INS_CLEAR_ERR &&
                            (typ == `ACD_CLEAR_ALL || typ == 8'(f + 1));
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b)           err_q[f] <= 1'b0;
            else if (flag_set[f]) err_q[f] <= 1'b1;
            else if (clr_hit[f])  err_q[f] <= 1'b0;
        end
    end

    // per interrupt enable; motor/bank and value bytes are ignored
    for (genvar n = 0; n < N_IRQ; n++) begin : g_irq
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) irq_en_q[n] <= 1'b0;
            else if (exec_go && typ == 8'(n) && ins == `ACD_INS_IRQ_EN) irq_en_q[n] <= 1'b1;
            else if (exec_go && typ == 8'(n) && ins == `ACD_INS_IRQ_DIS) irq_en_q[n] <= 1'b0;
        end
    end

    // global interrupt processing switch
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) irq_glob_q <= 1'b0;
        else if (exec_go && typ == `ACD_IRQ_ALL && ins == `ACD_INS_IRQ_EN) irq_glob_q <= 1'b1;
        else if (exec_go && typ == `ACD_IRQ_ALL && ins == `ACD_INS_IRQ_DIS) irq_glob_q <= 1'b0;
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign rx_ready     = rx_ready_q;
    assign tx_valid     = tx_valid_q;
    assign tx_data      = tx_data_q;
    assign accu         = accu_q;
    assign x_reg        = x_q;
    assign err_flags    = err_q;
    assign irq_enable   = irq_en_q;
    assign irq_global   = irq_glob_q;
    assign param_wr     = pwr_q;
    assign frame_reject = reject_q;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    property p_axis_wr;
        @(posedge clock) disable iff (!rst_b)
        exec_go && ins == `ACD_INS_ACCU_AXIS |=> pwr_q.valid && !pwr_q.global && pwr_q.value == $past(accu_q);
    endproperty
    a_axis_wr: assert property (p_axis_wr) else $error("axis copy missing");
    property p_glob_wr;
        @(posedge clock) disable iff (!rst_b)
        exec_go && ins == `ACD_INS_ACCU_GLOBAL |=> pwr_q.valid && pwr_q.global && pwr_q.index == $past(typ);
    endproperty
    a_glob_wr: assert property (p_glob_wr) else $error("global copy missing");
    property p_status;
        @(posedge clock) disable iff (!rst_b)
        exec_go |=> reply_q[2] == 8'h64 ##[1:2] tx_valid_q && tx_data_q == HOST_ADDR;
    endproperty
    a_status: assert property (p_status) else $error("reply status or start wrong");
    property p_clear_all;
        @(posedge clock) disable iff (!rst_b)
        exec_go && ins == `ACD_INS_CLEAR_ERR && typ == 8'h00 && flag_set == '0 |=> err_q == '0;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("clear all failed");
    property p_irq_on;
        @(posedge clock) disable iff (!rst_b)
        exec_go && ins == `ACD_INS_IRQ_EN && typ == 8'hff |=> irq_glob_q && $stable(irq_en_q);
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("global enable failed");
    property p_irq_off;
        @(posedge clock) disable iff (!rst_b)
        exec_go && ins == `ACD_INS_IRQ_DIS && typ == 8'hff |=> !irq_glob_q;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("global disable failed");
    property p_frame_len;
        @(posedge clock) disable iff (!rst_b)
        state_q == ACD_ST_RX && rx_valid && cnt_q == 4'h8 |=> state_q == ACD_ST_EXEC && cnt_q == 4'h0;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not nine bytes");
    property p_mul;
        @(posedge clock) disable iff (!rst_b)
        exec_go && ins == `ACD_INS_ACCU_X && typ == 8'h02 |=> accu_q == 32'($past(accu_q) * $past(x_q));
    endproperty
    a_mul: assert property (p_mul) else $error("multiply result wrong");
    property p_add;
        @(posedge clock) disable iff (!rst_b)
        exec_go && ins == `ACD_INS_ACCU_X && typ == 8'h00 |=> accu_q == $past(accu_q) + $past(x_q);
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");
    property p_bad_sum;
        @(posedge clock) disable iff (!rst_b)
        state_q == ACD_ST_EXEC && sum != frame_q[8] |=> state_q == ACD_ST_RX && reject_q && !tx_valid_q;
    endproperty
    a_bad_sum: assert property (p_bad_sum) else $error("bad checksum accepted");
    property p_sticky;
        @(posedge clock) disable iff (!rst_b)
        err_q[0] && !clr_hit[0] |=> err_q[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
endmodule : acd_cmd_decoder

// ---- acd_regs.svh ----
// constants for the accumulator/parameter/interrupt command decoder
// assumes byte-wide frames delivered one byte per valid cycle
`ifndef ACD_REGS_SVH
`define ACD_REGS_SVH
// -----------------------------------------------------------------
// frame layout
// -----------------------------------------------------------------
`define ACD_FRAME_LEN   4'h9
`define ACD_B_ADDR      4'h0
`define ACD_B_INSTR     4'h1
`define ACD_B_TYPE      4'h2
`define ACD_B_BANK      4'h3
`define ACD_B_SUM       4'h8
// -----------------------------------------------------------------
// instruction codes, special type values, reply status and flag count
// -----------------------------------------------------------------
`define ACD_INS_IRQ_EN      8'h19
`define ACD_INS_IRQ_DIS     8'h1a
`define ACD_INS_ACCU_X      8'h21
`define ACD_INS_ACCU_AXIS   8'h22
`define ACD_INS_ACCU_GLOBAL 8'h23
`define ACD_INS_CLEAR_ERR   8'h24
`define ACD_IRQ_ALL         8'hff
`define ACD_CLEAR_ALL       8'h00
`define ACD_STATUS_OK       8'h64
`define ACD_N_FLAGS         5
`endif

// ---- acd_pkg.sv ----
// types shared by the command decoder
// assumes acd_regs.svh supplies the numeric constants
package acd_pkg;
    // -------------------------------------------------------------
    // sequencer states
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        ACD_ST_RX   = 2'b00,  // gathering frame bytes
        ACD_ST_EXEC = 2'b01,  // check and execute
        ACD_ST_TX   = 2'b10   // sending reply
    } acd_state_t;
    // -------------------------------------------------------------
    // x-register operations selected by the type byte
    // -------------------------------------------------------------
    typedef enum logic [7:0] {
        ACD_XOP_ADD  = 8'h00,
        ACD_XOP_SUB  = 8'h01,
        ACD_XOP_MUL  = 8'h02,  // multiply_op
        ACD_XOP_DIV  = 8'h03,
        ACD_XOP_MOD  = 8'h04,
        ACD_XOP_AND  = 8'h05,
        ACD_XOP_OR   = 8'h06,
        ACD_XOP_XOR  = 8'h07,
        ACD_XOP_NOT  = 8'h08,
        ACD_XOP_LOAD = 8'h09,
        ACD_XOP_SWAP = 8'h0a
    } acd_xop_t;
    // parameter write toward the parameter store
    typedef struct packed {
        logic        valid;   // one-cycle strobe
        logic        global;  // 1 global, 0 axis
        logic [7:0]  index;   // parameter number
        logic [7:0]  bank;    // motor or bank
        logic [31:0] value;   // accumulator copy
    } acd_param_wr_t;
endpackage : acd_pkg

// ---- acd_host_model.sv ----
// host-side partner: sends nine-byte command frames and collects replies
// assumes the decoder byte handshake of the design, one clock domain
`timescale 1ns/1ps
module acd_host_model (
    input  wire logic       clock,
    input  wire logic       rst_b,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       rx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    // -------------------------------------------------------------
    // idle levels
    // -------------------------------------------------------------
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end

    // -------------------------------------------------------------
    // frame sender: called just after a rising edge
    // -------------------------------------------------------------
    task automatic send_frame(input logic [7:0] addr, ins, typ, bank, input logic [31:0] val, input logic bad_sum);
        logic [7:0] b [9];
        logic [7:0] sum;
        b   = '{addr, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        sum = 8'h00;
        for (int i = 0; i < 8; i++) sum = sum + b[i];
        b[8] = bad_sum ? ~sum : sum;                             // corrupt only on request
        for (int i = 0; i < 9; i++) begin
            rx_valid <= 1'b1;
            rx_data  <= b[i];
            // byte held until the edge that sees ready high
            do @(posedge clock); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_data  <= ~b[8];                                       // released line shows no stale byte
    endtask : send_frame

    // -------------------------------------------------------------
    // reply collector: pat gives the stall pattern of tx_ready
    // -------------------------------------------------------------
    task automatic get_reply(input logic [31:0] pat, output logic [71:0] r);
        int k;
        k = 0;
        for (int i = 0; i < 9; i++) begin
            do begin
                tx_ready <= pat[k % 32];
                k++;
                @(posedge clock);
            end while (!(tx_valid === 1'b1 && tx_ready === 1'b1));
            r = {r[63:0], tx_data};                              // msb byte first
        end
        tx_ready <= 1'b0;
    endtask : get_reply
endmodule : acd_host_model

// ---- tb.sv ----
// self-checking bench for the command decoder with a reference model
// assumes acd_pkg and acd_regs.svh compiled, host partner in its own file
`timescale 1ns/1ps
`include "acd_regs.svh"
module tb
    import acd_pkg::*;
;
    localparam logic [7:0] MOD_A  = 8'h01;
    localparam logic [7:0] HOST_A = 8'h02;
    logic          clock, rst_b, rx_valid, rx_ready, tx_valid, tx_ready, accu_load, irq_global, frame_reject;
    logic [7:0]    rx_data, tx_data;
    logic [31:0]   accu_load_val, accu, x_reg, irq_enable;
    logic [4:0]    flag_set, err_flags;
    acd_param_wr_t param_wr, pw_q;
    logic [31:0]   m_accu, m_x, m_irq;                          // reference state
    logic [4:0]    m_flags;
    logic          m_glob;
    int            seed = 58930;
    int            n_errors = 0, n_compared = 0, pw_n = 0, rej_n = 0, rn;

    // -------------------------------------------------------------
    // clock, instances, event monitors
    // -------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    acd_cmd_decoder #(.N_IRQ(32), .MODULE_ADDR(MOD_A), .HOST_ADDR(HOST_A)) dut (
        .clock(clock), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .accu_load(accu_load),
        .accu_load_val(accu_load_val), .flag_set(flag_set), .accu(accu), .x_reg(x_reg),
        .err_flags(err_flags), .irq_enable(irq_enable), .irq_global(irq_global),
        .param_wr(param_wr), .frame_reject(frame_reject));
    acd_host_model host (
        .clock(clock), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    // count strobes so a missing or doubled pulse is seen
    always @(posedge clock) begin
        if (param_wr.valid === 1'b1) begin
            pw_q = param_wr;
            pw_n++;
        end
        if (frame_reject === 1'b1) rej_n++;
    end

    // -------------------------------------------------------------
    // compare, closing and watchdog
    // -------------------------------------------------------------
    task automatic chk(input string what, input logic [71:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_of_test();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clock);                         // far beyond the ~2000 cycles needed
        n_errors++;
        end_of_test();
    end

    // -------------------------------------------------------------
    // reference model of one accepted frame
    // -------------------------------------------------------------
    task automatic model(input logic [7:0] ins, typ);
        int a, x;
        a = m_accu;
        x = m_x;
        case (ins)
            8'h21: case (typ)
                8'h00: a = a + x;
                8'h01: a = a - x;
                8'h02: a = a * x;
                8'h03: if (x != 0) a = a / x;                    // divide by zero leaves accu
                8'h04: if (x != 0) a = a % x;
                8'h05: a = a & x;
                8'h06: a = a | x;
                8'h07: a = a ^ x;
                8'h08: x = ~x;
                8'h09: x = a;
                8'h0a: begin a = m_x; x = m_accu; end
                default: ;                                       // unknown op changes nothing
            endcase
            8'h24: m_flags = (typ == 0) ? 5'h00 : (typ <= 5) ? m_flags & ~(5'h01 << (typ - 1)) : m_flags;
            8'h19, 8'h1a: if (typ == 8'hff) m_glob = (ins == 8'h19); else if (typ < 32) m_irq[typ] = (ins == 8'h19);
            default: ;
        endcase
        m_accu = a;
        m_x    = x;
    endtask : model
    task automatic check_state();
        chk("accu", m_accu, accu);
        chk("x_reg", m_x, x_reg);
        chk("err_flags", m_flags, err_flags);
        chk("irq_enable", m_irq, irq_enable);
        chk("irq_global", m_glob, irq_global);
    endtask : check_state

    // -------------------------------------------------------------
    // stimulus helpers, each entered just after a rising edge
    // -------------------------------------------------------------
    task automatic exec(input logic [7:0] ins, typ, bank, input logic [31:0] val);
        logic [71:0] r;
        logic [7:0]  s;
        logic [31:0] pre;
        int          pn;
        pre = m_accu;
        pn  = pw_n;
        host.send_frame(MOD_A, ins, typ, bank, val, 1'b0);
        host.get_reply($random(seed) | 32'h80000001, r);         // random stalls on the reply side
        s = HOST_A + MOD_A + 8'h64 + ins + pre[31:24] + pre[23:16] + pre[15:8] + pre[7:0];
        chk("reply", {HOST_A, MOD_A, 8'h64, ins, pre, s}, r);
        model(ins, typ);
        if (ins == 8'h22 || ins == 8'h23)
            chk("param_wr", {22'h0, 1'b1, ins == 8'h23, typ, bank, pre}, {22'h0, pw_q});
        chk("param_wr count", pn + ((ins == 8'h22 || ins == 8'h23) ? 1 : 0), pw_n);
        check_state();
    endtask : exec
    task automatic load_accu(input logic [31:0] v);
        accu_load     <= 1'b1;
        accu_load_val <= v;
        @(posedge clock);
        accu_load <= 1'b0;
        m_accu = v;
        @(posedge clock);
        chk("accu load", m_accu, accu);
    endtask : load_accu
    task automatic pulse_flags(input logic [4:0] v);
        flag_set <= v;
        @(posedge clock);
        flag_set <= 5'h00;
        m_flags = m_flags | v;
        @(posedge clock);
        chk("flag set", m_flags, err_flags);
    endtask : pulse_flags

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        rst_b = 1'b0; accu_load = 1'b0; accu_load_val = 32'h0; flag_set = 5'h00;
        m_accu = 32'h0; m_x = 32'h0; m_irq = 32'h0; m_flags = 5'h00; m_glob = 1'b0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        check_state();                                           // all state clear at reset release
        exec(8'h19, 8'h03, 8'h00, 32'h0);                        // first byte offered before ready rises
        for (int i = 0; i < 4; i++) begin
            load_accu($random(seed));
            exec(8'h22 + (i % 2), $random(seed), $random(seed), $random(seed));
        end
        for (int t = 0; t <= 11; t++) begin
            load_accu($random(seed) % 1000);                     // small x keeps mul and div meaningful
            exec(8'h21, 8'h09, 8'h00, 32'h0);
            load_accu($random(seed));
            exec(8'h21, t, $random(seed), $random(seed));
            exec(8'h23, 8'h2a, 8'h02, 32'h0);
        end
        pulse_flags($random(seed));
        for (int t = 0; t <= 6; t++) begin
            exec(8'h24, t, $random(seed), $random(seed));
            pulse_flags(5'h1f);
        end
        for (int i = 0; i < 12; i++)
            exec(8'h19 + ($random(seed) & 1), (i % 4 == 0) ? 8'hff : $random(seed) & 31, $random(seed), 32'h5);
        exec(8'h1a, 8'hff, 8'h00, 32'h0);
        for (int i = 0; i < 3; i++) begin
            rn = rej_n;
            host.send_frame(i == 1 ? 8'h05 : MOD_A, i == 2 ? 8'h1f : 8'h19, 8'hff, 8'h00, 32'h0, i == 0);
            repeat (4) @(posedge clock);
            chk("reject", rn + 1, rej_n);
            chk("no reply", 1'b0, tx_valid);
            chk("rx_ready", 1'b1, rx_ready);
            check_state();
        end
        end_of_test();
    end
endmodule : tb
